// ===== sbg_pkg.sv
package sbg_pkg;

  // ==========================================================
  // Register map (indices; byte address is four times the index)
  localparam logic [7:0] RCV_CTRL_IDX   = 8'h18;
  localparam logic [7:0] XMT_CTRL_IDX   = 8'h98;
  localparam logic [7:0] DIVISOR_IDX    = 8'h99;
  localparam logic [7:0] GEN_STATUS_IDX = 8'h9A;
  localparam int         ADDR_W         = 10;

  // ==========================================================
  // Reset values
  localparam logic [7:0] XMT_CTRL_RST = 8'h02;
  localparam logic [7:0] RCV_CTRL_RST = 8'h00;
  localparam logic [7:0] DIVISOR_RST  = 8'h00;

  // ==========================================================
  // Transmit control field positions
  localparam int CLK_SRC_BIT   = 7;
  localparam int SYNC_MODE_BIT = 4;
  localparam int HIGH_SPD_BIT  = 2;
  localparam int TSR_EMPTY_BIT = 1;
  // Transmit control bits that software can write
  localparam logic [7:0] XMT_CTRL_WMASK = 8'hF5;
  // Receive control: bits 7..3 writable, 2..0 reported by shift logic
  localparam logic [7:0] RCV_CTRL_WMASK = 8'hF8;

  // ==========================================================
  // Prescale terminal counts: divide by 64, 16 and 4
  localparam logic [5:0] SCALE_ASYNC_LOW  = 6'h3F;
  localparam logic [5:0] SCALE_ASYNC_HIGH = 6'h0F;
  localparam logic [5:0] SCALE_SYNC       = 6'h03;

  typedef enum logic [1:0] {
    SBG_RATE_ASYNC_LOW  = 2'b00,
    SBG_RATE_ASYNC_HIGH = 2'b01,
    SBG_RATE_SYNC       = 2'b10
  } sbg_rate_e;

endpackage

// ===== sbg_majority.sv
`timescale 1ns/10ps
module sbg_majority
  import sbg_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  // Samples
  input  wire logic sample_i,
  input  wire logic strobe_i,
  // Decision
  output logic      level_o,
  output logic      valid_o
);

  logic [1:0] samples_reg;
  logic [1:0] count_reg;

  function automatic logic vote(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // ==========================================================
  // Three-sample vote
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      samples_reg <= 2'h3;
      count_reg   <= 2'h0;
      level_o     <= 1'b1;
      valid_o     <= 1'b0;
    end
    else if (clk_en_i)
    begin
      valid_o <= 1'b0;
      if (strobe_i)
      begin
        samples_reg <= {samples_reg[0], sample_i};
        if (count_reg == 2'h2)
        begin
          count_reg <= 2'h0;
          level_o   <= vote(samples_reg[1], samples_reg[0], sample_i);
          valid_o   <= 1'b1;
        end
        else
        begin
          count_reg <= count_reg + 2'h1;
        end
      end
    end
  end

endmodule

// ===== sbg_top.sv
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
module sbg_top
  import sbg_pkg::*;
(
  // Clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       clk_en_i,
  // Avalon-MM slave
  input  wire logic [sbg_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  // Pins
  input  wire logic                       receive_data_pin_i,
  input  wire logic                       ext_bit_clk_i,
  // Shift logic status
  input  wire logic                       tsr_empty_i,
  input  wire logic [2:0]                 rx_status_i,
  // Shift logic timing and configuration
  output logic                            rate_tick_o,
  output logic                            rx_bit_o,
  output logic                            rx_bit_valid_o,
  output logic      [7:0]                 xmt_ctrl_o,
  output logic      [7:0]                 rcv_ctrl_o
);

  import sbg_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0] xmt_ctrl_reg;
  logic [7:0] rcv_ctrl_reg;
  logic [7:0] divisor_reg;
  logic       ack_reg;
  logic [7:0] rdata_reg;
  logic [5:0] pre_reg;
  logic [7:0] count_reg;
  logic       tick_reg;
  logic [1:0] rx_sync_reg;
  logic [1:0] ext_sync_reg;
  logic       ext_prev_reg;
  logic       sample_stb_reg;
  logic       bus_req;
  logic       wr_fire;
  logic       div_write;
  logic [7:0] word_idx;
  logic       sync_mode;
  logic       high_speed;
  logic       master_mode;
  logic       pre_done;
  logic [5:0] pre_last;
  logic [5:0] pre_mid;
  logic       ext_rise;
  logic       vote_level;
  logic       vote_valid;
  sbg_rate_e  rate_sel;

  // ==========================================================
  // Avalon decode: one wait state, then the answer
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    return idx == want;
  endfunction

  assign bus_req           = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req & ~ack_reg;
  assign word_idx          = avs_address_i[ADDR_W-1:2];
  // Writes land only on the edge where the master sees waitrequest low
  assign wr_fire           = avs_write_i & ack_reg & avs_byteenable_i[0];
  assign div_write         = wr_fire & hit(word_idx, DIVISOR_IDX);
  assign avs_readdata_o    = {24'h000000, rdata_reg};

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ack_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      rdata_reg <= 8'h00;
    end
    else if (clk_en_i && avs_read_i && !ack_reg)
    begin
      // Unmapped words read as zero
      if (hit(word_idx, XMT_CTRL_IDX))
        rdata_reg <= {xmt_ctrl_reg[7:2], tsr_empty_i, xmt_ctrl_reg[0]};
      else if (hit(word_idx, RCV_CTRL_IDX))
        rdata_reg <= {rcv_ctrl_reg[7:3], rx_status_i};
      else if (hit(word_idx, DIVISOR_IDX))
        rdata_reg <= divisor_reg;
      else if (hit(word_idx, GEN_STATUS_IDX))
        rdata_reg <= {6'h00, ~master_mode, vote_level};
      else
        rdata_reg <= 8'h00;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      xmt_ctrl_reg <= XMT_CTRL_RST;
      rcv_ctrl_reg <= RCV_CTRL_RST;
    end
    else if (clk_en_i && wr_fire)
    begin
      if (hit(word_idx, XMT_CTRL_IDX))
        xmt_ctrl_reg <= (avs_writedata_i[7:0] & XMT_CTRL_WMASK)
                        | (XMT_CTRL_RST & ~XMT_CTRL_WMASK);
      if (hit(word_idx, RCV_CTRL_IDX))
        rcv_ctrl_reg <= avs_writedata_i[7:0] & RCV_CTRL_WMASK;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      divisor_reg <= DIVISOR_RST;
    end
    else if (clk_en_i && div_write)
    begin
      divisor_reg <= avs_writedata_i[7:0];
    end
  end

  assign xmt_ctrl_o = {xmt_ctrl_reg[7:2], tsr_empty_i, xmt_ctrl_reg[0]};
  assign rcv_ctrl_o = {rcv_ctrl_reg[7:3], rx_status_i};

  // ==========================================================
  // Mode decode
  assign sync_mode   = xmt_ctrl_reg[SYNC_MODE_BIT];
  assign high_speed  = xmt_ctrl_reg[HIGH_SPD_BIT];
  // Clock source bit only matters in synchronous mode
  assign master_mode = ~sync_mode | xmt_ctrl_reg[CLK_SRC_BIT];

  always_comb
  begin
    if (sync_mode)
      rate_sel = SBG_RATE_SYNC;
    else if (high_speed)
      rate_sel = SBG_RATE_ASYNC_HIGH;
    else
      rate_sel = SBG_RATE_ASYNC_LOW;
  end

  always_comb
  begin
    case (rate_sel)
      SBG_RATE_ASYNC_LOW:  pre_last = SCALE_ASYNC_LOW;
      SBG_RATE_ASYNC_HIGH: pre_last = SCALE_ASYNC_HIGH;
      SBG_RATE_SYNC:       pre_last = SCALE_SYNC;
      default:             pre_last = SCALE_ASYNC_LOW;
    endcase
  end

  assign pre_mid  = {1'b0, pre_last[5:1]};
  assign pre_done = (pre_reg >= pre_last);

  // ==========================================================
  // Prescaler: a mode change mid-count ends the tick early, never late
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      pre_reg <= 6'h00;
    end
    else if (clk_en_i)
    begin
      if (div_write)
        pre_reg <= 6'h00;
      else if (pre_done)
        pre_reg <= 6'h00;
      else
        pre_reg <= pre_reg + 6'h01;
    end
  end

  // ==========================================================
  // Free-running 8-bit divisor timer
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      count_reg <= DIVISOR_RST;
      tick_reg  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      tick_reg <= 1'b0;
      if (div_write)
      begin
        count_reg <= avs_writedata_i[7:0];
      end
      else if (pre_done)
      begin
        if (count_reg == 8'h00)
        begin
          count_reg <= divisor_reg;
          tick_reg  <= 1'b1;
        end
        else
        begin
          count_reg <= count_reg - 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_sync_reg  <= 2'h3;
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rx_sync_reg  <= {rx_sync_reg[0], receive_data_pin_i};
      ext_sync_reg <= {ext_sync_reg[0], ext_bit_clk_i};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  assign ext_rise = ext_sync_reg[1] & ~ext_prev_reg;

  // Slave timing follows the external clock edge instead of the timer
  assign rate_tick_o = master_mode ? tick_reg : ext_rise;

  // ==========================================================
  // Three samples around mid-bit: prescale phases mid-1, mid, mid+1
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sample_stb_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      sample_stb_reg <= !div_write
                        && (count_reg == {1'b0, divisor_reg[7:1]})
                        && (pre_reg + 6'h01 >= pre_mid)
                        && (pre_reg <= pre_mid + 6'h01);
    end
  end

  sbg_majority u_majority (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .sample_i  (rx_sync_reg[1]),
    .strobe_i  (sample_stb_reg),
    .level_o   (vote_level),
    .valid_o   (vote_valid)
  );

  assign rx_bit_o       = vote_level;
  assign rx_bit_valid_o = vote_valid;

endmodule

// ===== sbg_asserts.sv
`timescale 1ns/10ps
module sbg_asserts
  import sbg_pkg::*;
(
  // Clock and reset
  input wire logic                       sys_clk_i,
  input wire logic                       sys_rst_i,
  // Bus
  input wire logic [sbg_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic                       avs_read_i,
  input wire logic                       avs_write_i,
  input wire logic [31:0]                avs_writedata_i,
  input wire logic [3:0]                 avs_byteenable_i,
  input wire logic                       avs_waitrequest_o,
  // Pins and shift logic
  input wire logic                       ext_bit_clk_i,
  input wire logic                       tsr_empty_i,
  input wire logic [2:0]                 rx_status_i,
  input wire logic                       rate_tick_o,
  input wire logic                       rx_bit_o,
  input wire logic                       rx_bit_valid_o,
  input wire logic [7:0]                 xmt_ctrl_o,
  input wire logic [7:0]                 rcv_ctrl_o
);
  // ========
  // Period tracking: only trusted after a divisor write or a tick
  logic [15:0] cnt_reg;
  logic [7:0]  div_reg;
  logic [2:0]  cfg_reg;
  logic        ok_reg;
  wire  [2:0]  cfg = {xmt_ctrl_o[CLK_SRC_BIT], xmt_ctrl_o[SYNC_MODE_BIT],
                      xmt_ctrl_o[HIGH_SPD_BIT]};
  wire  [15:0] per = (cfg[1] ? 16'h0004 : cfg[0] ? 16'h0010 : 16'h0040)
                     * (16'h0001 + {8'h00, div_reg});
  wire         steady = ok_reg && (cfg == cfg_reg) && (!cfg[1] || cfg[2]);
  wire         wr_div = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                        && avs_address_i[9:2] == DIVISOR_IDX;

  always_ff @(posedge sys_clk_i)
  begin
    cfg_reg <= cfg;
    cnt_reg <= cnt_reg + 16'h0001;
    if (sys_rst_i)
    begin
      ok_reg  <= 1'b0;
      div_reg <= DIVISOR_RST;
    end
    else if (wr_div)
    begin
      ok_reg  <= 1'b1;
      div_reg <= avs_writedata_i[7:0];
      // The write edge itself is count zero: the first tick lands a full period later
      cnt_reg <= 16'h0000;
    end
    else if (cfg != cfg_reg)
      ok_reg <= 1'b0;
    else if (rate_tick_o)
    begin
      ok_reg  <= 1'b1;
      cnt_reg <= 16'h0001;
    end
  end

  // ========
  // Properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_bus_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("bus answer late");
  a_tick_one_cycle: assert property (rate_tick_o |=> !rate_tick_o)
    else $error("tick too long");
  a_tick_period_exact: assert property (rate_tick_o && steady |-> cnt_reg == per)
    else $error("tick period wrong");
  a_tick_not_missed: assert property (steady |-> cnt_reg <= per)
    else $error("tick missing");
  // The pin is already one edge old when the rise is seen here, so two more edges remain
  a_slave_edge_tick: assert property (cfg[1] && !cfg[2] && $rose(ext_bit_clk_i)
    |-> ##2 rate_tick_o) else $error("slave tick missing");
  a_tsr_bit_shown: assert property (xmt_ctrl_o[TSR_EMPTY_BIT] == tsr_empty_i && !xmt_ctrl_o[3])
    else $error("transmit control status bits wrong");
  a_rx_status_shown: assert property (rcv_ctrl_o[2:0] == rx_status_i)
    else $error("receive status bits wrong");
  a_vote_on_valid: assert property ($changed(rx_bit_o) |-> rx_bit_valid_o)
    else $error("voted level moved without valid");
  a_valid_one_pulse: assert property (rx_bit_valid_o |=> !rx_bit_valid_o)
    else $error("valid too long");

  c_master_tick: cover property (rate_tick_o && steady);
  c_slave_tick: cover property (rate_tick_o && cfg[1] && !cfg[2]);
  c_vote_low: cover property (rx_bit_valid_o && !rx_bit_o);
endmodule

bind sbg_top sbg_asserts sbg_asserts_i (
  .sys_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_waitrequest_o, .ext_bit_clk_i, .tsr_empty_i, .rx_status_i,
  .rate_tick_o, .rx_bit_o, .rx_bit_valid_o, .xmt_ctrl_o, .rcv_ctrl_o
);

// ===== sbg_shift_model.sv
`timescale 1ns/10ps
module sbg_shift_model (
  // Clock and bench control
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        frame_i,
  input  wire logic        line_i,
  // Generator side
  input  wire logic        tick_i,
  output logic             tsr_empty_o,
  output logic             ext_clk_o,
  output logic             rx_pin_o,
  output logic      [15:0] tick_cnt_o
);
  logic [2:0] half_reg;

  // Shifter busy exactly while a frame runs
  assign tsr_empty_o = !frame_i;
  assign rx_pin_o    = line_i;

  // External clock rests low between frames
  always_ff @(posedge sys_clk_i)
  begin
    if (!frame_i)
    begin
      half_reg  <= 3'h0;
      ext_clk_o <= 1'b0;
    end
    else if (half_reg == 3'h5)
    begin
      half_reg  <= 3'h0;
      ext_clk_o <= !ext_clk_o;
    end
    else
      half_reg <= half_reg + 3'h1;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      tick_cnt_o <= 16'h0000;
    else if (tick_i)
      tick_cnt_o <= tick_cnt_o + 16'h0001;
  end
endmodule

// ===== sbg_top_bench.sv
`timescale 1ns/10ps
module sbg_top_bench;
  import sbg_pkg::*;
  localparam logic [9:0] RCV_A = {RCV_CTRL_IDX, 2'b00};
  localparam logic [9:0] XMT_A = {XMT_CTRL_IDX, 2'b00};
  localparam logic [9:0] DIV_A = {DIVISOR_IDX, 2'b00};
  localparam logic [9:0] STA_A = {GEN_STATUS_IDX, 2'b00};
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic [9:0]  avs_address_i = 10'h000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o, receive_data_pin_i, ext_bit_clk_i, tsr_empty_i;
  logic [2:0]  rx_status_i = 3'h5;
  logic        rate_tick_o, rx_bit_o, rx_bit_valid_o;
  logic [7:0]  xmt_ctrl_o, rcv_ctrl_o;
  logic        frame = 1'b0;
  logic        line = 1'b1;
  logic [15:0] tick_cnt;
  int          fails = 0;
  int          check_count = 0;
  logic [7:0]  cfg_tab [5] = '{8'h00, 8'h04, 8'h90, 8'h94, 8'h84};
  logic [7:0]  div_tab [5] = '{8'h03, 8'h00, 8'hFF, 8'h01, 8'h02};

  sbg_top sbg_top_i (
    .sys_clk_i, .sys_rst_i, .clk_en_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .receive_data_pin_i, .ext_bit_clk_i, .tsr_empty_i, .rx_status_i, .rate_tick_o,
    .rx_bit_o, .rx_bit_valid_o, .xmt_ctrl_o, .rcv_ctrl_o
  );
  sbg_shift_model sbg_shift_model_i (
    .sys_clk_i, .sys_rst_i, .frame_i(frame), .line_i(line), .tick_i(rate_tick_o),
    .tsr_empty_o(tsr_empty_i), .ext_clk_o(ext_bit_clk_i), .rx_pin_o(receive_data_pin_i),
    .tick_cnt_o(tick_cnt)
  );

  initial forever #12.5 sys_clk_i = !sys_clk_i;

  // ========
  // Tasks
  task automatic end_sim;
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic give_up;
    fails++;
    end_sim();
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [9:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge sys_clk_i);
    avs_read_i <= !we;
    avs_write_i <= we;
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_byteenable_i <= be;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0)
      give_up();
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'hF, q);
    chk("register", q, e);
  endtask
  task automatic wait_valid;
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (rx_bit_valid_o !== 1'b1 && n < 2000);
    if (rx_bit_valid_o !== 1'b1)
      give_up();
  endtask
  // Second divisor write must restart the timer
  task automatic period(input logic [7:0] cfg, input logic [7:0] x);
    int n;
    int e;
    e = (cfg[SYNC_MODE_BIT] ? 4 : cfg[HIGH_SPD_BIT] ? 16 : 64) * (x + 1);
    wr(XMT_A, cfg);
    wr(DIV_A, x);
    repeat (5) @(posedge sys_clk_i);
    wr(DIV_A, x);
    // The tick is registered: it shows one edge after its count ends
    @(posedge sys_clk_i);
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge sys_clk_i);
        n++;
      end
      while (rate_tick_o !== 1'b1 && n < 5000);
      if (rate_tick_o !== 1'b1)
        give_up();
      chk("tick period", n, e);
    end
  endtask

  // ========
  // Sequence
  initial
  begin
    logic [31:0] q;
    logic [15:0] c;
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    rd(XMT_A, 32'h02);
    rd(RCV_A, 32'h05);
    rd(DIV_A, 32'h00);
    rd(10'h3FC, 32'h00);
    wr(RCV_A, 8'hFF);
    rd(RCV_A, 32'hFD);
    wr(XMT_A, 8'hFF);
    rd(XMT_A, 32'hF7);
    wr(DIV_A, 8'hFF);
    bus(1'b1, DIV_A, 8'h12, 4'h0, q);
    rd(DIV_A, 32'hFF);
    foreach (cfg_tab[i]) period(cfg_tab[i], div_tab[i]);
    for (int v = 0; v < 2; v++)
    begin
      line <= v[0];
      // Three votes, so that the last one holds only samples taken after the change
      repeat (3) wait_valid();
      chk("voted level", {31'h0, rx_bit_o}, v);
      rd(STA_A, v);
    end
    wr(XMT_A, 8'h10);
    frame <= 1'b1;
    rd(XMT_A, 32'h10);
    rd(STA_A, 32'h03);
    c = tick_cnt;
    repeat (90) @(posedge sys_clk_i);
    frame <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    chk("slave ticks", {16'h0, tick_cnt - c}, 32'h8);
    end_sim();
  end
endmodule
